// *** design/tcr_defines.svh ***
/*
 * constants of the triggered capture recorder: register offsets, codes, sizes, timing.
 * assumes: included by bare name from the recorder and the bench.
 */
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TCR_REG_OPMODE   8'h00
`define TCR_REG_TRIG_CH  8'h04
`define TCR_REG_PRETRIG  8'h08
`define TCR_REG_LEVEL    8'h0c
`define TCR_REG_COND     8'h10
`define TCR_REG_REQUEST  8'h14
`define TCR_REG_OFFSET   8'h18
`define TCR_REG_LENGTH   8'h1c
`define TCR_REG_TARGET   8'h20
`define TCR_REG_STATUS   8'h24
`define TCR_REG_TRIGTIME 8'h28
`define TCR_REG_LENOUT   8'h2c
`define TCR_BUSY_BIT     16

// ****************************************
// operating modes, conditions, request modes
// ****************************************
`define TCR_OP_OSC1      5'h04
`define TCR_OP_OSC2      5'h08
`define TCR_OP_OSC4      5'h0c
`define TCR_OP_OSC8      5'h10
`define TCR_OP_FIFO      5'h01
`define TCR_COND_RISE    2'h0
`define TCR_COND_FALL    2'h1
`define TCR_COND_MANUAL  2'h2
`define TCR_MODE_START   8'h01
`define TCR_MODE_READ    8'h00
`define TCR_MODE_READ1   8'h80

// ****************************************
// return codes
// ****************************************
`define TCR_RC_OK        16'h0000
`define TCR_RC_NOCFG     16'h8002
`define TCR_RC_BADCH     16'h8005
`define TCR_RC_BADOFS    16'h8007
`define TCR_RC_NOSTART   16'h0004
`define TCR_RC_RECORDING 16'h7003
`define TCR_RC_TARGET    16'h8200
`define TCR_RC_LENOFS    16'h8400
`define TCR_RC_OVERFLOW  16'h8800
`define TCR_RC_RUN_FIRST 16'h7001
`define TCR_RC_RUN_NEXT  16'h7002
`define TCR_RC_WAIT_TRIG 16'h7023
`define TCR_RC_TRIGGERED 16'h7013

// ****************************************
// buffer sizes and timing
// ****************************************
`define TCR_BUF_LOG      5'd16
`define TCR_FIFO_LOG     5'd13
`define TCR_FIFO_CAP     17'd8190
`define TCR_PCT_FULL     7'd100
`define TCR_CLK_NS       100
`define TCR_TICK_NS      1000
`define TCR_RESP_OKAY    2'b00
`define TCR_RESP_DECERR  2'b11

`endif

// *** design/tcr_pkg.sv ***
/*
 * types of the triggered capture recorder.
 * assumes: tcr_defines.svh on the include path.
 */
package tcr_pkg;
	typedef enum logic [2:0] {REC_IDLE, REC_WAIT, REC_POST, REC_MANUAL, REC_FULL, REC_FIFO} tcr_rec_e;
	typedef enum logic {REQ_IDLE, REQ_READ} tcr_req_e;
	typedef struct packed {
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [4:0]  op_mode;
		logic [2:0]  trig_ch;
		logic [6:0]  pretrig;
		logic [15:0] level;
		logic [1:0]  cond;
		logic [31:0] offset;
		logic [31:0] length;
		logic [31:0] target;
		tcr_rec_e    rstate;
		logic [15:0] wp;
		logic [16:0] post_left;
		logic [15:0] base;
		logic [16:0] rec_len;
		logic [15:0] prev;
		logic [31:0] trig_time;
		logic [31:0] time_ctr;
		logic [3:0]  tick_div;
		logic [16:0] fifo_cnt;
		logic        fifo_ovf;
		logic        job_run;
		tcr_req_e    qstate;
		logic        q_single;
		logic        q_first;
		logic [2:0]  q_ch;
		logic [16:0] q_start;
		logic [16:0] q_idx;
		logic [16:0] q_count;
		logic [15:0] ret;
		logic [31:0] len_out;
		logic        out_valid;
		logic [15:0] out_data;
		logic [16:0] out_index;
	} tcr_state_s;
endpackage : tcr_pkg

// *** design/tcr_recorder.sv ***
/*
 * triggered capture recorder: oscilloscope recording of 1, 2, 4 or 8 and fifo recording of all 8 sample channels,
 * trigger detection, 1 us time stamp, request/busy job control, axi4-lite registers.
 * assumes: samples arrive synchronous to i_clock, one frame of 8 channels per valid pulse;
 * read data leaves on the o_rec_* stream into the host's target area.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
`include "tcr_defines.svh"

module tcr_recorder (
	input  wire logic         i_clock,
	input  wire logic         i_reset_n,
	input  wire logic         i_clock_enable,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         i_sample_valid,
	input  wire logic [127:0] i_sample_data,
	output logic              o_busy,
	output logic              o_rec_valid,
	output logic [15:0]       o_rec_data,
	output logic [16:0]       o_rec_index
);
	localparam int TICK_CYC = `TCR_TICK_NS / `TCR_CLK_NS;

	tcr_pkg::tcr_state_s s;
	tcr_pkg::tcr_state_s next_s;
	logic [15:0] mem [0:65535];

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		return a <= `TCR_REG_LENOUT && a[1:0] == 2'b00;
	endfunction : known

	// [2] oscilloscope, [1:0] log2 of channel count
	function automatic logic [2:0] osc_decode(input logic [4:0] op);
		unique case (op)
			`TCR_OP_OSC1: return 3'h4;
			`TCR_OP_OSC2: return 3'h5;
			`TCR_OP_OSC4: return 3'h6;
			`TCR_OP_OSC8: return 3'h7;
			default:      return 3'h0;
		endcase
	endfunction : osc_decode

	logic [2:0]  osc;
	logic        fifo;
	logic [4:0]  per_log;
	logic [16:0] per;
	logic [16:0] wrap;
	logic [3:0]  nch;
	logic [23:0] pre_prod;
	logic [16:0] pre_n;
	logic [15:0] cur;
	logic        rise;
	logic        fall;
	logic        fire;
	logic        rec_on;
	logic [15:0] wp_inc;
	logic [16:0] rd_sum;
	logic [16:0] rd_pos;
	logic [15:0] rd_addr;
	logic        wr_take;
	logic        rd_take;
	logic [7:0]  wa;
	logic [7:0]  ra;
	logic [7:0]  qmode;
	logic [7:0]  qch;
	logic [15:0] live_ret;
	logic [31:0] len_clamp;

	always_comb begin
		osc = osc_decode(s.op_mode);
		fifo = s.op_mode == `TCR_OP_FIFO;
		per_log = fifo ? `TCR_FIFO_LOG : 5'(`TCR_BUF_LOG - {3'h0, osc[1:0]});
		per = 17'h1 << per_log;
		wrap = fifo ? `TCR_FIFO_CAP : per;
		nch = fifo ? 4'h8 : 4'(4'h1 << osc[1:0]);
		pre_prod = 24'(per) * 24'((s.pretrig > `TCR_PCT_FULL) ? `TCR_PCT_FULL : s.pretrig);
		pre_n = 17'(pre_prod / 24'(`TCR_PCT_FULL));
		cur = i_sample_data[s.trig_ch*16 +: 16];
		rise = $signed(s.prev) <= $signed(s.level) && $signed(cur) > $signed(s.level);
		fall = $signed(s.prev) >= $signed(s.level) && $signed(cur) < $signed(s.level);
		fire = i_sample_valid && s.rstate == tcr_pkg::REC_WAIT
			&& ((s.cond == `TCR_COND_RISE && rise) || (s.cond == `TCR_COND_FALL && fall));
		rec_on = i_sample_valid && (s.rstate == tcr_pkg::REC_WAIT || s.rstate == tcr_pkg::REC_POST
			|| s.rstate == tcr_pkg::REC_MANUAL || s.rstate == tcr_pkg::REC_FIFO);
		wp_inc = (17'(s.wp) + 17'h1 == wrap) ? 16'h0 : 16'(s.wp + 16'h1);
		rd_sum = s.q_start + s.q_idx;
		rd_pos = (rd_sum >= wrap) ? 17'(rd_sum - wrap) : rd_sum;
		rd_addr = 16'((17'(s.q_ch) << per_log) | rd_pos);
		wr_take = s_axi_awvalid && s_axi_wvalid && !s.bvalid && i_clock_enable;
		rd_take = s_axi_arvalid && !s.rvalid && i_clock_enable;
		wa = s_axi_awaddr[7:0];
		ra = s_axi_araddr[7:0];
		qmode = s_axi_wdata[7:0];
		qch = s_axi_wdata[15:8];
		len_clamp = (s.length == 32'h0 || s.length > 32'(per)) ? 32'(per) : s.length;
		if (s.qstate == tcr_pkg::REQ_READ) begin
			live_ret = s.q_first ? `TCR_RC_RUN_FIRST : `TCR_RC_RUN_NEXT;
		end else if (s.job_run && s.rstate == tcr_pkg::REC_WAIT) begin
			live_ret = `TCR_RC_WAIT_TRIG;
		end else if (s.job_run && s.rstate == tcr_pkg::REC_POST) begin
			live_ret = `TCR_RC_TRIGGERED;
		end else if (s.job_run) begin
			live_ret = `TCR_RC_RECORDING;
		end else begin
			live_ret = s.ret;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.out_valid = 1'b0;
		if (32'(s.tick_div) == TICK_CYC - 1) begin
			next_s.tick_div = 4'h0;
			next_s.time_ctr = s.time_ctr + 32'h1;
		end else begin
			next_s.tick_div = s.tick_div + 4'h1;
		end

		// recording
		if (i_sample_valid) begin
			next_s.prev = cur;
		end
		if (rec_on) begin
			next_s.wp = wp_inc;
		end
		unique case (s.rstate)
			tcr_pkg::REC_WAIT: begin
				if (fire) begin
					next_s.trig_time = s.time_ctr;
					next_s.post_left = 17'(per - pre_n);
					next_s.rstate = tcr_pkg::REC_POST;
				end
			end
			tcr_pkg::REC_POST, tcr_pkg::REC_MANUAL: begin
				if (i_sample_valid) begin
					next_s.post_left = s.post_left - 17'h1;
					if (s.post_left <= 17'h1) begin
						next_s.rstate = tcr_pkg::REC_FULL;
						next_s.job_run = 1'b0;
						next_s.ret = `TCR_RC_OK;
						next_s.base = (s.rstate == tcr_pkg::REC_POST) ? wp_inc : 16'h0;
					end
				end
			end
			tcr_pkg::REC_FIFO: begin
				if (i_sample_valid) begin
					if (s.fifo_cnt == `TCR_FIFO_CAP) begin
						next_s.fifo_ovf = 1'b1;
					end else begin
						next_s.fifo_cnt = s.fifo_cnt + 17'h1;
					end
				end
			end
			default: begin
			end
		endcase

		// read streaming
		if (s.qstate == tcr_pkg::REQ_READ) begin
			next_s.out_valid = 1'b1;
			next_s.out_data = mem[rd_addr];
			next_s.out_index = s.q_idx;
			next_s.q_idx = s.q_idx + 17'h1;
			next_s.q_first = 1'b0;
			if (s.q_idx + 17'h1 >= s.q_count) begin
				next_s.qstate = tcr_pkg::REQ_IDLE;
				next_s.len_out = 32'(s.q_count);
				next_s.ret = (fifo && s.fifo_ovf) ? `TCR_RC_OVERFLOW : `TCR_RC_OK;
				if (fifo) begin
					next_s.fifo_ovf = s.rstate == tcr_pkg::REC_FIFO && i_sample_valid && s.fifo_cnt == `TCR_FIFO_CAP;
				end
			end
		end

		// register writes
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_take) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = known(wa) ? `TCR_RESP_OKAY : `TCR_RESP_DECERR;
			unique case (wa)
				`TCR_REG_OPMODE:  next_s.op_mode = 5'(merge(32'(s.op_mode), s_axi_wdata, s_axi_wstrb));
				`TCR_REG_TRIG_CH: next_s.trig_ch = 3'(merge(32'(s.trig_ch), s_axi_wdata, s_axi_wstrb));
				`TCR_REG_PRETRIG: next_s.pretrig = 7'(merge(32'(s.pretrig), s_axi_wdata, s_axi_wstrb));
				`TCR_REG_LEVEL:   next_s.level = 16'(merge(32'(s.level), s_axi_wdata, s_axi_wstrb));
				`TCR_REG_COND:    next_s.cond = 2'(merge(32'(s.cond), s_axi_wdata, s_axi_wstrb));
				`TCR_REG_OFFSET:  next_s.offset = merge(s.offset, s_axi_wdata, s_axi_wstrb);
				`TCR_REG_LENGTH:  next_s.length = merge(s.length, s_axi_wdata, s_axi_wstrb);
				`TCR_REG_TARGET:  next_s.target = merge(s.target, s_axi_wdata, s_axi_wstrb);
				default: begin
				end
			endcase
			if (wa <= `TCR_REG_COND) begin
				next_s.rstate = tcr_pkg::REC_IDLE;
				next_s.job_run = 1'b0;
			end
			// a request while a read streams is dropped
			if (wa == `TCR_REG_REQUEST && s.qstate == tcr_pkg::REQ_IDLE) begin
				if (osc[2] == 1'b0 && !fifo) begin
					next_s.ret = `TCR_RC_NOCFG;
				end else if (qmode == `TCR_MODE_START) begin
					next_s.wp = 16'h0;
					next_s.len_out = 32'h0;
					next_s.ret = `TCR_RC_OK;
					if (fifo) begin
						next_s.rstate = tcr_pkg::REC_FIFO;
						next_s.fifo_cnt = 17'h0;
						next_s.fifo_ovf = 1'b0;
					end else if (s.cond == `TCR_COND_MANUAL) begin
						next_s.rstate = tcr_pkg::REC_MANUAL;
						next_s.post_left = 17'(len_clamp);
						next_s.rec_len = 17'(len_clamp);
						next_s.job_run = 1'b1;
					end else begin
						next_s.rstate = tcr_pkg::REC_WAIT;
						next_s.rec_len = per;
						next_s.job_run = 1'b1;
					end
				end else if (qmode == `TCR_MODE_READ || qmode == `TCR_MODE_READ1) begin
					next_s.q_ch = qch[2:0];
					next_s.q_single = qmode == `TCR_MODE_READ1;
					next_s.q_first = 1'b1;
					next_s.q_idx = 17'h0;
					if (32'(qch) >= 32'(nch)) begin
						next_s.ret = `TCR_RC_BADCH;
					end else if (fifo) begin
						if (s.rstate != tcr_pkg::REC_FIFO) begin
							next_s.ret = `TCR_RC_NOSTART;
						end else if (32'(s.fifo_cnt) > s.target) begin
							next_s.ret = `TCR_RC_TARGET;
						end else if (s.fifo_cnt != 17'h0) begin
							next_s.q_count = s.fifo_cnt;
							next_s.q_start = (17'(s.wp) >= s.fifo_cnt) ? 17'(17'(s.wp) - s.fifo_cnt)
								: 17'(17'(s.wp) + `TCR_FIFO_CAP - s.fifo_cnt);
							next_s.fifo_cnt = i_sample_valid ? 17'h1 : 17'h0;
							next_s.qstate = tcr_pkg::REQ_READ;
						end else begin
							next_s.len_out = 32'h0;
							next_s.ret = `TCR_RC_OK;
						end
					end else if (s.rstate != tcr_pkg::REC_FULL) begin
						next_s.ret = s.job_run ? `TCR_RC_RECORDING : `TCR_RC_NOSTART;
					end else if (s.offset >= 32'(s.rec_len)) begin
						next_s.ret = `TCR_RC_BADOFS;
					end else if (s.length > 32'(s.rec_len) || s.offset + s.length > 32'(s.rec_len)
						|| s.length == 32'h0) begin
						next_s.ret = `TCR_RC_LENOFS;
					end else if (s.length > s.target) begin
						next_s.ret = `TCR_RC_TARGET;
					end else begin
						next_s.q_count = 17'(s.length);
						next_s.q_start = 17'(17'(s.base) + 17'(s.offset));
						next_s.qstate = tcr_pkg::REQ_READ;
					end
				end
			end
		end

		// register reads
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_take) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = known(ra) ? `TCR_RESP_OKAY : `TCR_RESP_DECERR;
			unique case (ra)
				`TCR_REG_OPMODE:   next_s.rdata = 32'(s.op_mode);
				`TCR_REG_TRIG_CH:  next_s.rdata = 32'(s.trig_ch);
				`TCR_REG_PRETRIG:  next_s.rdata = 32'(s.pretrig);
				`TCR_REG_LEVEL:    next_s.rdata = 32'(s.level);
				`TCR_REG_COND:     next_s.rdata = 32'(s.cond);
				`TCR_REG_OFFSET:   next_s.rdata = s.offset;
				`TCR_REG_LENGTH:   next_s.rdata = s.length;
				`TCR_REG_TARGET:   next_s.rdata = s.target;
				`TCR_REG_STATUS:   next_s.rdata = {15'h0, o_busy, live_ret};
				`TCR_REG_TRIGTIME: next_s.rdata = (osc[2] && s.cond != `TCR_COND_MANUAL
					&& ((s.job_run && s.rstate == tcr_pkg::REC_POST)
					|| (s.rstate == tcr_pkg::REC_FULL && s.ret == `TCR_RC_OK))) ? s.trig_time : 32'h0;
				`TCR_REG_LENOUT:   next_s.rdata = s.len_out;
				default:           next_s.rdata = 32'h0;
			endcase
		end
	end

	// ****************************************
	// registers and storage
	// ****************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s <= '0;
		end else if (i_clock_enable) begin
			s <= next_s;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_clock_enable && rec_on) begin
			for (int c = 0; c < 8; c++) begin
				if (c < int'(nch)) begin
					mem[16'((17'(c) << per_log) | 17'(s.wp))] <= i_sample_data[c*16 +: 16];
				end
			end
		end
	end

	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = rd_take;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rdata   = s.rdata;
	assign o_busy        = s.qstate == tcr_pkg::REQ_READ || s.job_run;
	assign o_rec_valid   = s.out_valid;
	assign o_rec_data    = s.out_data;
	assign o_rec_index   = s.out_index;

	// ****************************************
	// checks
	// ****************************************
	sequence seq_armed;
		s.rstate == tcr_pkg::REC_WAIT && i_clock_enable && fire && !wr_take;
	endsequence
	sequence seq_stamped;
		s.rstate == tcr_pkg::REC_POST && s.trig_time == $past(s.time_ctr);
	endsequence

	a_trig_stamp: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		seq_armed |=> seq_stamped) else $error("trigger time not captured");
	a_manual_quiet: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		s.cond == `TCR_COND_MANUAL |-> s.rstate != tcr_pkg::REC_WAIT && s.rstate != tcr_pkg::REC_POST)
		else $error("edge monitoring active in manual start");
	a_rise_cross: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		fire && s.cond == `TCR_COND_RISE |-> $signed(s.prev) <= $signed(s.level)
		&& $signed(cur) > $signed(s.level)) else $error("rising trigger without crossing");
	a_read_busy: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		s.qstate == tcr_pkg::REQ_READ |-> o_busy) else $error("busy low while reading");
	a_read_done: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		s.qstate == tcr_pkg::REQ_READ && i_clock_enable && s.q_idx + 17'h1 >= s.q_count && !s.job_run
		|=> !o_busy && s.len_out == $past(32'(s.q_count))) else $error("read end wrong");
	a_cfg_stop: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		wr_take && i_clock_enable && wa == `TCR_REG_LEVEL |=> s.rstate == tcr_pkg::REC_IDLE && !s.job_run)
		else $error("recording not stopped by parameter write");
	a_osc_notfull: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		s.qstate == tcr_pkg::REQ_READ && !fifo |-> s.rstate == tcr_pkg::REC_FULL)
		else $error("oscilloscope read before buffer full");
	a_post_count: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		seq_armed |=> s.post_left == $past(17'(per - pre_n))) else $error("post count wrong");
	a_fifo_read: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		s.qstate == tcr_pkg::REQ_READ && fifo |-> s.q_count != 17'h0 && s.q_count <= `TCR_FIFO_CAP)
		else $error("fifo read count wrong");
endmodule : tcr_recorder

// *** verif/tcr_recorder_tb.sv ***
/*
 * self-checking bench of the recorder: registers, manual, edge and fifo jobs.
 * assumes: tcr_sample_src feeds frames; axi4-lite master lives in the tasks.
 */
`include "tcr_defines.svh"
module tcr_recorder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tcr_row_s;
	logic        i_clock, i_reset_n, i_clock_enable, restart, i_sample_valid, o_busy, o_rec_valid;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	logic [15:0] limit, o_rec_data;
	logic [16:0] o_rec_index;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, tt;
	logic [127:0] i_sample_data;
	logic [15:0] got_q[$];
	int          n_mismatch = 0;
	int          n_compared = 0;
	tcr_row_s    rows [7] = '{'{`TCR_REG_TRIG_CH, 32'hd, 32'h5, `TCR_RESP_OKAY},
		'{`TCR_REG_PRETRIG, 32'h32, 32'h32, `TCR_RESP_OKAY}, '{`TCR_REG_LEVEL, 32'h8100, 32'h8100, `TCR_RESP_OKAY},
		'{`TCR_REG_COND, 32'h2, 32'h2, `TCR_RESP_OKAY}, '{`TCR_REG_LENGTH, 32'h1234, 32'h1234, `TCR_RESP_OKAY},
		'{`TCR_REG_REQUEST, 32'h0, 32'h0, `TCR_RESP_OKAY}, '{8'h40, 32'h5, 32'h0, `TCR_RESP_DECERR}};

	tcr_recorder tcr_recorder_i (.i_clock, .i_reset_n, .i_clock_enable, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .i_sample_valid, .i_sample_data, .o_busy, .o_rec_valid, .o_rec_data, .o_rec_index);
	tcr_sample_src tcr_sample_src_i (.i_clock, .i_reset_n, .i_restart(restart), .i_limit(limit),
		.o_valid(i_sample_valid), .o_data(i_sample_data));

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `TCR_RESP_OKAY);
		logic aw = 1'b1;
		logic w = 1'b1;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge i_clock);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(posedge i_clock); while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = `TCR_RESP_OKAY);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do @(posedge i_clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge i_clock); while (!s_axi_rvalid);
		d = s_axi_rdata;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `TCR_RESP_OKAY);
		logic [31:0] d;
		rd(a, d, er);
		chk(d, e);
	endtask : rchk

	task automatic wait_idle(input int max);
		for (int i = 0; i < max && o_busy !== 1'b0; i++) @(posedge i_clock);
		chk({31'h0, o_busy}, 32'h0);
	endtask : wait_idle

	task automatic burst(input logic [15:0] n);
		restart <= 1'b1;
		limit <= n;
		@(posedge i_clock);
		restart <= 1'b0;
	endtask : burst

	// read job: n samples expected, k0 < 0 skips the value check
	task automatic rq(input logic [7:0] ch, input logic [31:0] ofs, len, tgt, input int n, k0,
		input logic [7:0] m, input logic [31:0] st);
		got_q.delete();
		wr(`TCR_REG_OFFSET, ofs);
		wr(`TCR_REG_LENGTH, len);
		wr(`TCR_REG_TARGET, tgt);
		wr(`TCR_REG_REQUEST, {16'h0, ch, m});
		if (n > 0) chk({31'h0, o_busy}, 32'h1);
		wait_idle(200);
		@(posedge i_clock);
		chk(32'(got_q.size()), 32'(n));
		for (int i = 0; i < n && k0 >= 0; i++) chk(32'(got_q[i]), 32'(16'((k0 + i) * 16 + ch)));
		rchk(`TCR_REG_STATUS, st);
		if (n > 0) rchk(`TCR_REG_LENOUT, 32'(n));
	endtask : rq

	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// delivered samples arrive in index order
	always @(posedge i_clock) begin
		if (o_rec_valid === 1'b1) begin
			chk({15'h0, o_rec_index}, 32'(got_q.size()));
			got_q.push_back(o_rec_data);
		end
	end

	initial begin
		repeat (60000) @(posedge i_clock);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, restart} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, limit} = '0;
		s_axi_wstrb = 4'hf;
		i_clock_enable = 1'b1;
		i_reset_n = 1'b0;
		repeat (4) @(posedge i_clock);
		chk({30'h0, o_busy, o_rec_valid}, 32'h0);
		i_reset_n <= 1'b1;
		@(posedge i_clock);
		rq(8'h0, 0, 1, 1, 0, -1, `TCR_MODE_READ1, {16'h0, `TCR_RC_NOCFG});
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rchk(rows[i].a, rows[i].e, rows[i].r);
		end
		// manual oscilloscope job of four frames
		wr(`TCR_REG_OPMODE, {27'h0, `TCR_OP_OSC8});
		wr(`TCR_REG_COND, {30'h0, `TCR_COND_MANUAL});
		wr(`TCR_REG_LENGTH, 32'h4);
		wr(`TCR_REG_REQUEST, {24'h0, `TCR_MODE_START});
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_RECORDING});
		burst(16'd6);
		wait_idle(100);
		rchk(`TCR_REG_STATUS, 32'h0);
		rchk(`TCR_REG_TRIGTIME, 32'h0);
		rq(8'h8, 0, 1, 1, 0, -1, `TCR_MODE_READ, {16'h0, `TCR_RC_BADCH});
		rq(8'h3, 4, 1, 1, 0, -1, `TCR_MODE_READ, {16'h0, `TCR_RC_BADOFS});
		rq(8'h3, 2, 3, 3, 0, -1, `TCR_MODE_READ, {16'h0, `TCR_RC_LENOFS});
		rq(8'h3, 1, 2, 1, 0, -1, `TCR_MODE_READ, {16'h0, `TCR_RC_TARGET});
		rq(8'h3, 1, 2, 2, 2, 1, `TCR_MODE_READ1, 32'h0);
		rq(8'h5, 0, 4, 4, 4, 0, `TCR_MODE_READ, 32'h0);
		// rising edge on channel 2 across 0x100, crossing at frame 16
		wr(`TCR_REG_TRIG_CH, 32'h2);
		wr(`TCR_REG_PRETRIG, 32'h0);
		wr(`TCR_REG_LEVEL, 32'h100);
		wr(`TCR_REG_COND, {30'h0, `TCR_COND_RISE});
		wr(`TCR_REG_REQUEST, {24'h0, `TCR_MODE_START});
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_WAIT_TRIG});
		burst(16'd9000);
		repeat (60) @(posedge i_clock);
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_TRIGGERED});
		rd(`TCR_REG_TRIGTIME, tt);
		chk({31'h0, tt <= $time / 1000 && tt + 10 >= $time / 1000}, 32'h1);
		got_q.delete();
		wr(`TCR_REG_REQUEST, {16'h0, 8'h2, `TCR_MODE_READ});
		repeat (4) @(posedge i_clock);
		chk(32'(got_q.size()), 32'h0);
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_TRIGGERED});
		wait_idle(20000);
		rchk(`TCR_REG_STATUS, 32'h0);
		rchk(`TCR_REG_TRIGTIME, tt);
		rq(8'h2, 0, 4, 4, 4, -1, `TCR_MODE_READ, 32'h0);
		// falling edge: source stopped high, restart drops channel 2 below the level
		burst(16'd0);
		wr(`TCR_REG_COND, {30'h0, `TCR_COND_FALL});
		wr(`TCR_REG_REQUEST, {24'h0, `TCR_MODE_START});
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_WAIT_TRIG});
		burst(16'd4);
		repeat (10) @(posedge i_clock);
		rchk(`TCR_REG_STATUS, {15'h0, 1'b1, `TCR_RC_TRIGGERED});
		wr(`TCR_REG_LEVEL, 32'h100);
		chk({31'h0, o_busy}, 32'h0);
		// fifo: five frames, offset and length ignored
		wr(`TCR_REG_OPMODE, {27'h0, `TCR_OP_FIFO});
		wr(`TCR_REG_REQUEST, {24'h0, `TCR_MODE_START});
		rchk(`TCR_REG_STATUS, 32'h0);
		burst(16'd5);
		repeat (20) @(posedge i_clock);
		rq(8'h6, 1000, 99, 4, 0, -1, `TCR_MODE_READ, {16'h0, `TCR_RC_TARGET});
		rq(8'h6, 1000, 99, 5, 5, 0, `TCR_MODE_READ, 32'h0);
		report_and_stop();
	end
endmodule : tcr_recorder_tb

// *** verif/tcr_sample_src.sv ***
/*
 * frame source standing in for the converter side: bursts of 8-channel frames,
 * channel c of frame k carries k*16+c, one frame every second cycle.
 * assumes: shares i_clock with the recorder; a restart pulse begins a burst.
 */
module tcr_sample_src (
	input  wire logic         i_clock,
	input  wire logic         i_reset_n,
	input  wire logic         i_restart,
	input  wire logic [15:0]  i_limit,
	output logic              o_valid,
	output logic [127:0]      o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] k;
	logic        ph;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			k <= 16'h0;
			ph <= 1'b0;
			o_valid <= 1'b0;
			o_data <= '0;
		end else if (i_restart) begin
			k <= 16'h0;
			ph <= 1'b0;
			o_valid <= 1'b0;
		end else begin
			ph <= ~ph;
			o_valid <= ph && (k < i_limit);
			// data outside a frame inverts every cycle, so after a burst it alternates with the last value
			o_data <= ~o_data;
			if (ph && (k < i_limit)) begin
				k <= k + 16'h1;
				for (int c = 0; c < 8; c++) begin
					o_data[16*c +: 16] <= {k[11:0], 4'(c)};
				end
			end
		end
	end
endmodule : tcr_sample_src
